// >>> logic/fcs_regs.svh
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
`define FCS_CTRL_OFS   12'h000
`define FCS_STAT_OFS   12'h004
`define FCS_LEN_OFS    12'h008
`define FCS_CNT_OFS    12'h00c
`define FCS_OFS_W      12
`define FCS_CTRL_W     7
`define FCS_CTRL_RST   7'h39
`define FCS_PREAMBLE   4'h2
`define FCS_PRE_W      4
`define FCS_LEN_W      24
`define FCS_ERR_W      4
`define FCS_ERR_OK     4'h6
`define FCS_FRAME_BITS 16
`define FCS_FRAMES     8
`define FCS_SYS_MHZ    50
`define FCS_MWAIT_US   250
`define FCS_MODE_CLKS  2
`define FCS_DONE_TAIL  3
`define FCS_CONFIG_CLOCK_HALF  4
`define FCS_STEP_MAX   3'h7
`define FCS_PIN_RST    12'hfff
`endif

// >>> logic/fcs_pkg.sv
`default_nettype none
package fcs_pkg;
  typedef enum logic [3:0] {
    ST_CLEAR, ST_LASTCLR, ST_WAITINIT, ST_MWAIT, ST_MODECAP,
    ST_CONFIG, ST_STARTUP, ST_USER, ST_ERROR
  } fcs_state_e;
  typedef enum logic [1:0] {PH_HUNT, PH_LEN, PH_FRAME} fcs_phase_e;
  typedef struct packed {
    logic       useUserClk;
    logic [1:0] gsrAt;
    logic [1:0] ioAt;
    logic [1:0] doneAt;
  } fcs_ctrl_s;
  typedef struct packed {
    logic       programN;
    logic       initIn;
    logic       cfgClk;
    logic       dataIn;
    logic       tck;
    logic       tdi;
    logic       userClk;
    logic       trig;
    logic       jtagCfg;
    logic [2:0] mode;
  } fcs_pins_s;
endpackage
`default_nettype wire

// >>> logic/fcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // The first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // fcs_sync
`default_nettype wire

// >>> logic/fcs_config_ctrl.sv
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`include "fcs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module fcs_config_ctrl #(
  parameter int MWAIT_CYC  = `FCS_MWAIT_US * `FCS_SYS_MHZ,
  parameter int FRAME_BITS = `FCS_FRAME_BITS,
  parameter int FRAMES     = `FCS_FRAMES,
  parameter int CONFIG_CLOCK_HALF  = `FCS_CONFIG_CLOCK_HALF
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        programN,
  input  wire logic        initIn,
  output var  logic        initOut,
  output var  logic        initOe,
  output var  logic        doneOut,
  output var  logic        doneOe,
  input  wire logic [2:0]  modePins,
  input  wire logic        configClockIn,
  output var  logic        configClockOut,
  output var  logic        configClockOe,
  input  wire logic        dataIn,
  output var  logic        daisyOut,
  input  wire logic        tck,
  input  wire logic        tdi,
  input  wire logic        jtagConfigCmd,
  input  wire logic        userStartupClock,
  input  wire logic        readbackTrigger,
  output var  logic        readbackStart,
  output var  logic        scanCmdsEnable,
  output var  logic        globalSetResetActive,
  output var  logic        userIoRelease
);
  localparam int CNT_W = $clog2(MWAIT_CYC + 1);
  localparam int FB_W  = $clog2(FRAME_BITS + `FCS_ERR_W + 1);
  localparam int FR_W  = $clog2(FRAMES + 1);
  if (FRAME_BITS < 1 || FRAMES < 1 || CONFIG_CLOCK_HALF < 1 || MWAIT_CYC < 1) begin : g_bad_param
    $error("fcs_config_ctrl: parameters out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  fcs_pkg::fcs_pins_s pin, pinPrev_q;
  fcs_pkg::fcs_state_e state_q;
  fcs_pkg::fcs_phase_e phase_q;
  fcs_pkg::fcs_ctrl_s ctrl_q;
  logic [`FCS_LEN_W-1:0] lenCount_q, clkCount_q, lenShift_q;
  logic [`FCS_PRE_W-1:0] preShift_q;
  logic [`FCS_ERR_W-1:0] errShift_q;
  logic [FB_W-1:0]       bitCnt_q;
  logic [FR_W-1:0]       frameCnt_q, clrCnt_q;
  logic [CNT_W-1:0]      waitCnt_q;
  logic [4:0]            lenBits_q;
  logic [2:0]            mode_q, stepCnt_q;
  logic [$clog2(CONFIG_CLOCK_HALF+1)-1:0] div_q;
  logic memFull_q, frameErr_q, doneHigh_q, finished_q, phaseBridgeStage_q;
  logic isMaster, cfgEdge, cfgBit, stepEdge, clrPassEnd, lenMatch;

  fcs_sync #(.W(12), .RST_VAL(`FCS_PIN_RST)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       ({programN, initIn, configClockIn, dataIn, tck, tdi, userStartupClock,
               readbackTrigger, jtagConfigCmd, modePins}),
    .q       (pin)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) pinPrev_q <= `FCS_PIN_RST;
    else     pinPrev_q <= pin;
  end

  // Master drives its own clock; scan loading takes its edges from the test clock
  assign isMaster = ~mode_q[0];
  always_comb begin
    if (pin.jtagCfg) begin
      cfgEdge = pin.tck & ~pinPrev_q.tck;
      cfgBit  = pin.tdi;
    end else if (isMaster) begin
      cfgEdge = configClockOe && !configClockOut && div_q == CONFIG_CLOCK_HALF[$bits(div_q)-1:0];
      cfgBit  = pin.dataIn;
    end else begin
      cfgEdge = pin.cfgClk & ~pinPrev_q.cfgClk;
      cfgBit  = pin.dataIn;
    end
  end
  assign clrPassEnd = clrCnt_q == FR_W'(FRAMES - 1);
  assign lenMatch   = memFull_q && clkCount_q == lenCount_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q   <= fcs_pkg::ST_CLEAR;
      clrCnt_q  <= '0;
      waitCnt_q <= '0;
      mode_q    <= '1;
    end else if (!pin.programN) begin
      state_q  <= fcs_pkg::ST_CLEAR;
      clrCnt_q <= '0;
    end else begin
      case (state_q)
        fcs_pkg::ST_CLEAR, fcs_pkg::ST_LASTCLR: begin
          clrCnt_q <= clrPassEnd ? '0 : clrCnt_q + 1'b1;
          if (clrPassEnd)
            state_q <= (state_q == fcs_pkg::ST_CLEAR) ? fcs_pkg::ST_LASTCLR
                                                      : fcs_pkg::ST_WAITINIT;
        end
        fcs_pkg::ST_WAITINIT: begin
          waitCnt_q <= '0;
          if (pin.initIn)
            state_q <= (pin.mode[0] == 1'b0) ? fcs_pkg::ST_MWAIT : fcs_pkg::ST_MODECAP;
        end
        fcs_pkg::ST_MWAIT: begin
          waitCnt_q <= waitCnt_q + 1'b1;
          if (waitCnt_q == CNT_W'(MWAIT_CYC - 1)) begin
            waitCnt_q <= '0;
            state_q   <= fcs_pkg::ST_MODECAP;
          end
        end
        fcs_pkg::ST_MODECAP: begin
          waitCnt_q <= waitCnt_q + 1'b1;
          if (waitCnt_q == CNT_W'(`FCS_MODE_CLKS - 1)) begin
            mode_q  <= pin.mode;
            state_q <= fcs_pkg::ST_CONFIG;
          end
        end
        fcs_pkg::ST_CONFIG: begin
          if (frameErr_q)    state_q <= fcs_pkg::ST_ERROR;
          else if (lenMatch) state_q <= fcs_pkg::ST_STARTUP;
        end
        fcs_pkg::ST_STARTUP: if (finished_q) state_q <= fcs_pkg::ST_USER;
        fcs_pkg::ST_USER, fcs_pkg::ST_ERROR: state_q <= state_q;
        default: state_q <= fcs_pkg::ST_CLEAR;
      endcase
    end
  end

  // Init is open drain: only ever pulled low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      initOut <= 1'b0;
      initOe  <= 1'b1;
    end else begin
      initOut <= 1'b0;
      initOe  <= !pin.programN || state_q == fcs_pkg::ST_CLEAR
              || state_q == fcs_pkg::ST_LASTCLR || state_q == fcs_pkg::ST_ERROR
              || (state_q == fcs_pkg::ST_CONFIG && frameErr_q);
    end
  end

  // Master clock runs on through a mismatch, so the counter wraps and meets again
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_q          <= '0;
      configClockOut <= 1'b0;
      configClockOe  <= 1'b0;
    end else begin
      configClockOe <= isMaster && !pin.jtagCfg
                    && (state_q == fcs_pkg::ST_CONFIG || state_q == fcs_pkg::ST_STARTUP);
      if (!configClockOe) begin
        div_q          <= '0;
        configClockOut <= 1'b0;
      end else if (div_q == CONFIG_CLOCK_HALF[$bits(div_q)-1:0]) begin
        div_q          <= '0;
        configClockOut <= !configClockOut;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst || state_q != fcs_pkg::ST_CONFIG && state_q != fcs_pkg::ST_STARTUP)
      clkCount_q <= '0;
    else if (cfgEdge)
      clkCount_q <= clkCount_q + 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst || state_q != fcs_pkg::ST_CONFIG) begin
      phase_q    <= fcs_pkg::PH_HUNT;
      preShift_q <= '1;
      errShift_q <= '0;
      lenBits_q  <= '0;
      bitCnt_q   <= '0;
      frameCnt_q <= '0;
      memFull_q  <= (state_q == fcs_pkg::ST_STARTUP || state_q == fcs_pkg::ST_USER) && !rst;
      // The error flag stays visible while loading is halted
      frameErr_q <= state_q == fcs_pkg::ST_ERROR && !rst;
      if (rst || state_q != fcs_pkg::ST_STARTUP && state_q != fcs_pkg::ST_USER)
        daisyOut <= 1'b1;
      else if (cfgEdge)
        daisyOut <= cfgBit;
      if (rst) begin
        lenCount_q <= '0;
        lenShift_q <= '0;
      end
    end else if (cfgEdge && !frameErr_q) begin
      daisyOut <= cfgBit;
      case (phase_q)
        fcs_pkg::PH_HUNT: begin
          preShift_q <= {preShift_q[`FCS_PRE_W-2:0], cfgBit};
          if ({preShift_q[`FCS_PRE_W-2:0], cfgBit} == `FCS_PREAMBLE)
            phase_q <= fcs_pkg::PH_LEN;
        end
        fcs_pkg::PH_LEN: begin
          lenShift_q <= {lenShift_q[`FCS_LEN_W-2:0], cfgBit};
          lenBits_q  <= lenBits_q + 1'b1;
          if (lenBits_q == 5'(`FCS_LEN_W - 1)) begin
            lenCount_q <= {lenShift_q[`FCS_LEN_W-2:0], cfgBit};
            phase_q    <= fcs_pkg::PH_FRAME;
          end
        end
        fcs_pkg::PH_FRAME: begin
          if (memFull_q) begin
            daisyOut <= cfgBit;
          end else begin
            daisyOut   <= 1'b1;
            errShift_q <= {errShift_q[`FCS_ERR_W-2:0], cfgBit};
            bitCnt_q   <= bitCnt_q + 1'b1;
            if (bitCnt_q == FB_W'(FRAME_BITS + `FCS_ERR_W)) begin
              bitCnt_q   <= '0;
              frameErr_q <= {errShift_q[`FCS_ERR_W-2:0], cfgBit} != `FCS_ERR_OK;
              frameCnt_q <= frameCnt_q + 1'b1;
              memFull_q  <= frameCnt_q == FR_W'(FRAMES - 1);
            end
          end
        end
        default: phase_q <= fcs_pkg::PH_HUNT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The bridge costs one user-clock edge, hence the one-cycle uncertainty
  assign stepEdge = ctrl_q.useUserClk ? (pin.userClk & ~pinPrev_q.userClk) && phaseBridgeStage_q
                                      : cfgEdge;
  always_ff @(posedge sys_clk) begin
    if (rst || state_q != fcs_pkg::ST_STARTUP && state_q != fcs_pkg::ST_USER) begin
      phaseBridgeStage_q <= 1'b0;
      stepCnt_q          <= '0;
    end else begin
      if (pin.userClk & ~pinPrev_q.userClk)
        phaseBridgeStage_q <= 1'b1;
      if (stepEdge && stepCnt_q != `FCS_STEP_MAX)
        stepCnt_q <= stepCnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || state_q != fcs_pkg::ST_STARTUP && state_q != fcs_pkg::ST_USER) begin
      doneHigh_q           <= 1'b0;
      doneOe               <= 1'b1;
      userIoRelease        <= 1'b0;
      globalSetResetActive <= 1'b1;
      finished_q           <= 1'b0;
      scanCmdsEnable       <= 1'b0;
    end else begin
      doneHigh_q           <= stepCnt_q >= {1'b0, ctrl_q.doneAt};
      doneOe               <= stepCnt_q < {1'b0, ctrl_q.doneAt};
      userIoRelease        <= stepCnt_q >= {1'b0, ctrl_q.ioAt};
      globalSetResetActive <= stepCnt_q < {1'b0, ctrl_q.gsrAt};
      finished_q           <= stepCnt_q >= 3'({1'b0, ctrl_q.doneAt} + `FCS_DONE_TAIL);
      scanCmdsEnable       <= finished_q;
    end
  end

  // Trigger already high at completion counts as a rising trigger
  always_ff @(posedge sys_clk) begin
    if (rst) readbackStart <= 1'b0;
    else     readbackStart <= finished_q && pin.trig
                              && (!pinPrev_q.trig || state_q == fcs_pkg::ST_STARTUP);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) doneOut <= 1'b0;
    else     doneOut <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero-wait slave: read data registered at the address phase
  logic                 wrPend_q;
  logic [`FCS_OFS_W-1:0] wrAddr_q;
  logic                 addrPhase;
  assign addrPhase = hsel && htrans[1] && hready;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
      wrPend_q  <= 1'b0;
      wrAddr_q  <= '0;
      ctrl_q    <= `FCS_CTRL_RST;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_q  <= addrPhase && hwrite;
      wrAddr_q  <= haddr[`FCS_OFS_W-1:0];
      if (wrPend_q && wrAddr_q == `FCS_CTRL_OFS)
        ctrl_q <= hwdata[`FCS_CTRL_W-1:0];
      if (addrPhase && !hwrite) begin
        case (haddr[`FCS_OFS_W-1:0])
          `FCS_CTRL_OFS: hrdata <= {25'h0, ctrl_q};
          `FCS_STAT_OFS: hrdata <= {16'h0, 1'b0, mode_q, state_q, scanCmdsEnable,
                                    finished_q, doneHigh_q, memFull_q, frameErr_q,
                                    !initOe, globalSetResetActive, userIoRelease};
          `FCS_LEN_OFS:  hrdata <= {8'h0, lenCount_q};
          `FCS_CNT_OFS:  hrdata <= {8'h0, clkCount_q};
          default:       hrdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_progLow;
    !pin.programN;
  endsequence
  property p_err_init;
    @(posedge sys_clk) disable iff (rst) $rose(frameErr_q) |=> initOe [*2];
  endproperty
  a_err_init: assert property (p_err_init) else $error("error without init low");
  property p_prog_clear;
    @(posedge sys_clk) disable iff (rst) s_progLow |=> state_q == fcs_pkg::ST_CLEAR;
  endproperty
  a_prog_clear: assert property (p_prog_clear) else $error("no clear on program");
  property p_prog_init;
    @(posedge sys_clk) disable iff (rst) s_progLow |=> initOe;
  endproperty
  a_prog_init: assert property (p_prog_init) else $error("init not driven");
  property p_last_pass;
    @(posedge sys_clk) disable iff (rst)
      $rose(state_q == fcs_pkg::ST_WAITINIT) |-> $past(state_q) == fcs_pkg::ST_LASTCLR;
  endproperty
  a_last_pass: assert property (p_last_pass) else $error("final clear skipped");
  property p_done_cond;
    @(posedge sys_clk) disable iff (rst)
      $rose(state_q == fcs_pkg::ST_STARTUP) |-> $past(memFull_q && clkCount_q == lenCount_q);
  endproperty
  a_done_cond: assert property (p_done_cond) else $error("done without match");
  property p_count;
    @(posedge sys_clk) disable iff (rst)
      cfgEdge && state_q == fcs_pkg::ST_CONFIG |=> clkCount_q == $past(clkCount_q) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("clock counter slip");
  property p_preamble;
    @(posedge sys_clk) disable iff (rst)
      state_q == fcs_pkg::ST_CONFIG && phase_q == fcs_pkg::PH_HUNT && cfgEdge
      && {preShift_q[`FCS_PRE_W-2:0], cfgBit} == `FCS_PREAMBLE |=> phase_q == fcs_pkg::PH_LEN;
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble missed");
  property p_io_step;
    @(posedge sys_clk) disable iff (rst)
      $rose(userIoRelease) |-> $past(stepCnt_q) >= {1'b0, ctrl_q.ioAt};
  endproperty
  a_io_step: assert property (p_io_step) else $error("I/O released early");
  property p_gsr_step;
    @(posedge sys_clk) disable iff (rst)
      $fell(globalSetResetActive) |-> $past(stepCnt_q) >= {1'b0, ctrl_q.gsrAt};
  endproperty
  a_gsr_step: assert property (p_gsr_step) else $error("set/reset released early");
  property p_scan_gate;
    @(posedge sys_clk) disable iff (rst) readbackStart |-> finished_q && scanCmdsEnable;
  endproperty
  a_scan_gate: assert property (p_scan_gate) else $error("readback before finish");
endmodule // fcs_config_ctrl
`default_nettype wire

// >>> dv/fcs_cfg_source.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_cfg_source (
  output var logic configClockIn,
  output var logic dataIn
);
  initial begin
    configClockIn = 1'b0;
    dataIn        = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One rising edge per bit; the clock stands low between calls
  task automatic send(input logic b);
    dataIn = b;
    #80 configClockIn = 1'b1;
    #80 configClockIn = 1'b0;
    // Hold time is over: show the inverse so a stale bit never passes
    dataIn = ~b;
  endtask
endmodule // fcs_cfg_source
`default_nettype wire

// >>> dv/fcs_config_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_config_ctrl_tb;
  localparam int FB = 16;
  localparam int NF = 8;
  typedef struct {logic [31:0] val; logic [31:0] msk;} fcs_note_s;

  logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, modePins;
  logic        programN, initIn, initOut, initOe, doneOut, doneOe, extHold;
  logic        configClockIn, configClockOut, configClockOe, dataIn, daisyOut;
  logic        tck, tdi, jtagConfigCmd, userStartupClock, readbackTrigger;
  logic        readbackStart, scanCmdsEnable, globalSetResetActive, userIoRelease;
  int          failCount, numChecks, pulses;
  int          seed = 73830;
  fcs_note_s   noteQ[$];

  assign hready = hreadyout;
  // Open-drain init wire with pull-up, low if either side pulls
  assign initIn = ~(initOe | extHold);
  // Scan loading reuses the source: the test clock follows its clock while selected
  assign tck = jtagConfigCmd & configClockIn;
  assign tdi = dataIn;

  fcs_config_ctrl #(.MWAIT_CYC(20), .FRAME_BITS(FB), .FRAMES(NF), .CONFIG_CLOCK_HALF(4)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .programN(programN),
    .initIn(initIn), .initOut(initOut), .initOe(initOe), .doneOut(doneOut),
    .doneOe(doneOe), .modePins(modePins), .configClockIn(configClockIn),
    .configClockOut(configClockOut), .configClockOe(configClockOe), .dataIn(dataIn),
    .daisyOut(daisyOut), .tck(tck), .tdi(tdi), .jtagConfigCmd(jtagConfigCmd),
    .userStartupClock(userStartupClock), .readbackTrigger(readbackTrigger),
    .readbackStart(readbackStart), .scanCmdsEnable(scanCmdsEnable),
    .globalSetResetActive(globalSetResetActive), .userIoRelease(userIoRelease)
  );

  fcs_cfg_source i_src (.configClockIn(configClockIn), .dataIn(dataIn));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic logic [31:0] stv(input fcs_pkg::fcs_state_e s);
    return {20'h0, s, 8'h0};
  endfunction

  // Single AHB-Lite word transfer; a read leaves its expectation for the monitor
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     input logic [31:0] exp, input logic [31:0] msk);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= addr;
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    if (!wr) noteQ.push_back('{exp, msk});
    do @(posedge sys_clk); while (hready !== 1'b1);
  endtask

  // Read data are taken at the edge that closes the data phase
  logic rdPhase = 1'b0;
  always @(posedge sys_clk) begin
    if (rdPhase && hready === 1'b1 && noteQ.size() > 0) begin
      check(hrdata & noteQ[0].msk, noteQ[0].val, "register read");
      check(32'(hresp), 32'h0, "okay response");
      void'(noteQ.pop_front());
    end
    if (hready === 1'b1) rdPhase = hsel && htrans[1] && !hwrite;
  end

  always @(posedge sys_clk) if (readbackStart === 1'b1) pulses++;

  ////////////////////////////////////////////////////////////////////////////
  // One reprogram and load; bad puts a wrong error field into the third frame
  task automatic run(input int dA, input int iA, input int gA, input logic bad,
                     input int trig, input int tail);
    logic [31:0] len;
    logic [2:0]  md;
    logic [15:0] dw;
    logic        b;
    int          k;
    k = $unsigned($random(seed)) % 4;
    md = {2'($random(seed)), 1'b1};
    len = 32'(k + 28 + NF * (FB + 5));
    pulses = 0;
    programN <= 1'b0;
    modePins <= md;
    repeat (20) @(posedge sys_clk);
    check(32'(initOe), 32'h1, "init pulled by reprogram");
    ahb(1'b0, 32'h4, 32'h0, stv(fcs_pkg::ST_CLEAR), 32'hf00);
    extHold  <= 1'b1;
    programN <= 1'b1;
    repeat (60) @(posedge sys_clk);
    check(32'(initOe), 32'h0, "init released after last clear");
    ahb(1'b0, 32'h4, 32'h0, stv(fcs_pkg::ST_WAITINIT), 32'hf00);
    extHold <= 1'b0;
    repeat (10) @(posedge sys_clk);
    ahb(1'b0, 32'h4, 32'h0, {17'h0, md, 4'(fcs_pkg::ST_CONFIG), 8'h0}, 32'h7f00);
    #7;
    repeat (k) i_src.send(1'b1);
    for (int i = 3; i >= 0; i--) i_src.send(4'h2 >> i);
    for (int i = 23; i >= 0; i--) i_src.send(len[i]);
    for (int f = 0; f < NF; f++) begin
      dw = 16'($random(seed));
      i_src.send(1'b0);
      for (int i = FB - 1; i >= 0; i--) i_src.send(dw[i]);
      for (int i = 3; i >= 0; i--) i_src.send(((bad && f == 2) ? 4'h9 : 4'h6) >> i);
    end
    if (bad) begin
      repeat (4) @(posedge sys_clk);
      check(32'(initOe), 32'h1, "init pulled on frame error");
      ahb(1'b0, 32'h4, 32'h0, 32'h8, 32'h8);
      check(32'(doneOe), 32'h1, "no done after error");
    end else begin
      ahb(1'b0, 32'h8, 32'h0, len, 32'hffffff);
      ahb(1'b0, 32'hc, 32'h0, len, 32'hffffff);
      check(32'(doneOe), 32'h1, "done before start-up");
      for (int s = 1; s <= tail; s++) begin
        b = 1'($random(seed));
        #7;
        i_src.send(b);
        repeat (2) @(posedge sys_clk);
        check(32'(daisyOut), 32'(b), "daisy follows data");
        check(32'(!doneOe), 32'(s >= dA), "done step");
        check(32'(userIoRelease), 32'(s >= iA), "io release step");
        check(32'(globalSetResetActive), 32'(s < gA), "set/reset step");
        check(32'(scanCmdsEnable), 32'(s >= dA + 3), "scan enable");
      end
      check(32'(pulses), 32'(trig), "readback on finish");
      check(32'({initOut, doneOut, configClockOe}), 32'h0, "no drive high, no clock");
    end
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    programN = 1'b1;
    extHold = 1'b0;
    modePins = 3'b111;
    jtagConfigCmd = 1'b0;
    userStartupClock = 1'b0;
    readbackTrigger = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0, 32'h39, 32'h7f);
    ahb(1'b1, 32'h10, 32'hffffffff, 32'h0, 32'h0);
    ahb(1'b0, 32'h10, 32'h0, 32'h0, 32'hffffffff);
    run(1, 2, 3, 1'b0, 0, 6);
    run(1, 2, 3, 1'b1, 0, 0);
    ahb(1'b1, 32'h0, 32'h27, 32'h0, 32'h0);
    ahb(1'b0, 32'h0, 32'h0, 32'h27, 32'h7f);
    readbackTrigger <= 1'b1;
    jtagConfigCmd   <= 1'b1;
    run(3, 1, 2, 1'b0, 1, 8);
    // Master start: mode pins low, extra init wait, then the block drives its own clock
    jtagConfigCmd <= 1'b0;
    modePins      <= 3'b000;
    programN      <= 1'b0;
    repeat (20) @(posedge sys_clk);
    programN <= 1'b1;
    repeat (30) @(posedge sys_clk);
    ahb(1'b0, 32'h4, 32'h0, stv(fcs_pkg::ST_MWAIT), 32'hf00);
    repeat (20) @(posedge sys_clk);
    ahb(1'b0, 32'h4, 32'h0, stv(fcs_pkg::ST_CONFIG), 32'h7f00);
    check(32'(configClockOe), 32'h1, "master drives its clock");
    conclude();
  end

  // Three loads and a master start take about 5300 cycles; allow a wide margin
  initial begin
    #800000;
    failCount++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end
endmodule // fcs_config_ctrl_tb
`default_nettype wire
